// ---- core/swseq_top.v ----
// Notes on behaviour
// RL1 - mode select picks trapezoidal or sine windows; here low select idles with all phases driven and no windows
// RL2 - window setting pair chosen by window count
// RL3 - six-window crosses 60 degrees apart, measured
// RL4 - after open delay float the sensed phase
// RL5 - ignore comparator during blanking period
// RL6 - search after open delay plus blanking
// RL7 - missed cross enters six-window recovery
// RL8 - recovery opens windows on all phases
// RL9 - software keeps delay plus blanking under 60
// RL10 - lead angle interpolated between duty settings
// RL11 - window counts 6, 3, 2, 1 meanings
// RL12 - all phases driven except sensed in window
// RL13 - lead angle clamped to maximum limit
`timescale 1ns/1ns
`include "swseq_defines.vh"
module swseq_top #(
   parameter [15:0] PERIOD_INIT = 16'h4E20
) (
   // clock and reset
   input  wire       mclk_in,
   input  wire       nrst_in,
   // mode configuration
   input  wire       sine_drive_select_in,
   input  wire [1:0] window_count_select_in,
   // window settings per count
   input  wire [5:0] six_win_open_delay_in,
   input  wire [5:0] six_win_blank_period_in,
   input  wire [5:0] three_win_open_delay_in,
   input  wire [5:0] three_win_blank_period_in,
   input  wire [5:0] two_win_open_delay_in,
   input  wire [5:0] two_win_blank_period_in,
   input  wire [5:0] one_win_open_delay_in,
   input  wire [5:0] one_win_blank_period_in,
   input  wire [5:0] recovery_open_delay_in,
   input  wire [5:0] recovery_blank_period_in,
   // lead angle settings
   input  wire [4:0] advance_at_zero_duty_in,
   input  wire [4:0] advance_at_full_duty_in,
   input  wire [4:0] advance_max_clamp_in,
   // modulator and sense
   input  wire [7:0] duty_in,
   input  wire [2:0] pwm_in,
   input  wire [2:0] zc_in,
   // driver side
   output reg  [2:0] phase_pwm_out,
   output reg  [2:0] phase_drive_en_out,
   // status
   output reg        zc_event_out,
   output reg        recovery_out,
   output reg  [2:0] cross_index_out,
   output reg  [4:0] lead_angle_out
);

   // sectors from one detection to the next wanted cross
   function [2:0] sect_of;
      input [1:0] c;
      begin
         case (c)
            `SWSEQ_WC6: sect_of = 3'h1;
            `SWSEQ_WC3: sect_of = 3'h2;
            `SWSEQ_WC2: sect_of = 3'h3;
            default:    sect_of = 3'h6;
         endcase
      end
   endfunction

   // whether a cross index belongs to a window count
   function allowed;
      input [2:0] i;
      input [1:0] c;
      begin
         case (c)
            `SWSEQ_WC6: allowed = 1'b1;
            `SWSEQ_WC3: allowed = ~i[0];
            `SWSEQ_WC2: allowed = (i == 3'h0) || (i == 3'h3);
            default:    allowed = (i == 3'h0);
         endcase
      end
   endfunction

   // phase sensed for a cross index; odd indices are falling
   function [1:0] phase_of;
      input [2:0] i;
      begin
         case (i)
            3'h0, 3'h3: phase_of = `SWSEQ_PH_U;
            3'h2, 3'h5: phase_of = `SWSEQ_PH_V;
            default:    phase_of = `SWSEQ_PH_W;
         endcase
      end
   endfunction

   // add modulo the cross count
   function [2:0] idx_add;
      input [2:0] i;
      input [2:0] k;
      reg   [3:0] s;
      begin
         s = {1'b0, i} + {1'b0, k};
         if (s >= `SWSEQ_NUM_CROSS)
            s = s - `SWSEQ_NUM_CROSS;
         idx_add = s[2:0];
      end
   endfunction

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg         rec_r;
   reg         rec_nxt;
   reg  [2:0]  tgt_r;
   reg  [2:0]  tgt_nxt;
   reg  [1:0]  cnt_cur_r;
   reg  [15:0] period_r;
   reg  [2:0]  kmeas_r;
   reg  [16:0] acc_r;
   reg  [9:0]  ang_r;
   reg  [15:0] cnt_r;
   reg         s_prev_r;
   reg  [5:0]  open_d;
   reg  [5:0]  blank_p;
   reg  [2:0]  float_nxt;

   // count held for the whole interval so a select change cannot move base
   wire [1:0]  cnt_eff   = cnt_cur_r;
   wire [2:0]  k_act     = sect_of(cnt_eff);
   wire [9:0]  base      = {1'b0, k_act, 6'h00} - `SWSEQ_SECTOR_TICKS;
   wire [9:0]  t_open    = base + {4'h0, open_d};
   wire [9:0]  t_search  = t_open + {4'h0, blank_p};
   wire [9:0]  t_end     = base + `SWSEQ_SEARCH_END;
   wire [1:0]  ph        = phase_of(tgt_r);
   wire        s_now     = zc_in[ph] ^ tgt_r[0];
   wire        in_search = (state_r == `SWSEQ_ST_SEARCH);
   wire        hit       = in_search && s_now && !s_prev_r;
   wire        timeout   = in_search && !hit && (ang_r >= t_end);
   wire [1:0]  cnt_nxt   = rec_nxt ? `SWSEQ_WC6 : window_count_select_in;
   wire [16:0] acc_sum   = acc_r + {8'h00, kmeas_r, 6'h00};
   wire        tick      = (acc_sum >= {1'b0, period_r});

   // setting pair for the active window count
   always @* begin
      case (cnt_eff)
         `SWSEQ_WC6: begin
            open_d  = rec_r ? recovery_open_delay_in                 // RL7
                            : six_win_open_delay_in;                 // RL2
            blank_p = rec_r ? recovery_blank_period_in
                            : six_win_blank_period_in;
         end
         `SWSEQ_WC3: begin
            open_d  = three_win_open_delay_in;
            blank_p = three_win_blank_period_in;
         end
         `SWSEQ_WC2: begin
            open_d  = two_win_open_delay_in;
            blank_p = two_win_blank_period_in;
         end
         default: begin
            open_d  = one_win_open_delay_in;
            blank_p = one_win_blank_period_in;
         end
      endcase
   end

   // window sequence, recovery entry and exit, next cross index
   always @* begin
      state_nxt = state_r;
      rec_nxt   = rec_r;
      tgt_nxt   = tgt_r;
      case (state_r)
         `SWSEQ_ST_IDLE: begin
            if (sine_drive_select_in) begin                      // RL1
               state_nxt = `SWSEQ_ST_WAIT;
               rec_nxt   = 1'b1;
            end
         end
         `SWSEQ_ST_WAIT: begin
            if (ang_r >= t_open)                                 // RL4
               state_nxt = `SWSEQ_ST_BLANK;
         end
         `SWSEQ_ST_BLANK: begin
            if (ang_r >= t_search)                               // RL5 RL6
               state_nxt = `SWSEQ_ST_SEARCH;
         end
         `SWSEQ_ST_SEARCH: begin
            if (hit) begin
               state_nxt = `SWSEQ_ST_WAIT;
               if (rec_r && allowed(tgt_r, window_count_select_in))
                  rec_nxt = 1'b0;
               else if (!rec_r && !allowed(tgt_r, window_count_select_in))
                  rec_nxt = 1'b1;                                // RL11
            end else if (timeout) begin
               state_nxt = `SWSEQ_ST_WAIT;
               rec_nxt   = 1'b1;                                 // RL7 RL8
            end
         end
         default: state_nxt = `SWSEQ_ST_IDLE;
      endcase
      if (hit)
         tgt_nxt = idx_add(tgt_r, sect_of(cnt_nxt));             // RL11
      else if (timeout)
         tgt_nxt = idx_add(tgt_r, 3'h1);
      if (!sine_drive_select_in) begin
         state_nxt = `SWSEQ_ST_IDLE;
         tgt_nxt   = 3'h0;
      end
   end

   // sensed phase floats from window open to detection
   always @* begin
      float_nxt = 3'h0;
      if (state_nxt == `SWSEQ_ST_BLANK || state_nxt == `SWSEQ_ST_SEARCH)
         float_nxt[phase_of(tgt_nxt)] = 1'b1;                    // RL12
   end

   // lead angle interpolation over duty and clamp
   wire [5:0]  la_diff = {1'b0, advance_at_full_duty_in}
                       - {1'b0, advance_at_zero_duty_in};
   wire [8:0]  duty_x  = {1'b0, duty_in} + {8'h00, duty_in[7]};
   wire signed [15:0] la_prod = $signed(la_diff) * $signed({1'b0, duty_x});
   wire [6:0]  la_sum  = {2'b00, advance_at_zero_duty_in}
                       + la_prod[14:8];                          // RL10
   wire [4:0]  la_clip = (la_sum[4:0] > advance_max_clamp_in)
                       ? advance_max_clamp_in : la_sum[4:0];     // RL13

   // state, angle timing and outputs
   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_r            <= `SWSEQ_ST_IDLE;
         rec_r              <= 1'b0;
         cnt_cur_r          <= `SWSEQ_WC6;
         tgt_r              <= 3'h0;
         period_r           <= PERIOD_INIT;
         kmeas_r            <= 3'h1;
         acc_r              <= 17'h00000;
         ang_r              <= 10'h000;
         cnt_r              <= 16'h0000;
         s_prev_r           <= 1'b0;
         phase_pwm_out      <= 3'h0;
         phase_drive_en_out <= 3'h0;
         zc_event_out       <= 1'b0;
         recovery_out       <= 1'b0;
         cross_index_out    <= 3'h0;
         lead_angle_out     <= 5'h00;
      end else begin
         state_r  <= state_nxt;
         rec_r    <= rec_nxt;
         tgt_r    <= tgt_nxt;
         s_prev_r <= s_now;
         if (hit) begin
            period_r <= cnt_r;                                   // RL3
            kmeas_r  <= k_act;
         end
         if (hit || timeout || state_r == `SWSEQ_ST_IDLE) begin
            cnt_cur_r <= cnt_nxt;                                // RL2
            acc_r <= 17'h00000;
            ang_r <= 10'h000;
            cnt_r <= 16'h0000;
         end else begin
            acc_r <= tick ? acc_sum - {1'b0, period_r} : acc_sum;
            ang_r <= tick ? ang_r + 10'h001 : ang_r;
            if (cnt_r != `SWSEQ_CNT_MAX)
               cnt_r <= cnt_r + 16'h0001;
         end
         phase_pwm_out      <= pwm_in & ~float_nxt;
         phase_drive_en_out <= ~float_nxt;                       // RL12
         zc_event_out       <= hit;
         recovery_out       <= rec_nxt;
         cross_index_out    <= tgt_nxt;
         lead_angle_out     <= la_clip;
      end
   end

endmodule // swseq_top

// ---- core/swseq_defines.vh ----
`ifndef SWSEQ_DEFINES_VH
`define SWSEQ_DEFINES_VH

// window count select encodings
`define SWSEQ_WC6           2'h0
`define SWSEQ_WC3           2'h1
`define SWSEQ_WC2           2'h2
`define SWSEQ_WC1           2'h3

// sequencer states
`define SWSEQ_ST_IDLE       2'h0
`define SWSEQ_ST_WAIT       2'h1
`define SWSEQ_ST_BLANK      2'h2
`define SWSEQ_ST_SEARCH     2'h3

// angle ticks: one 60 degree sector is 64 ticks
`define SWSEQ_SECTOR_TICKS  10'h040
// search gives up 96 ticks (90 degrees) past the sector start
`define SWSEQ_SEARCH_END    10'h060
// phase codes
`define SWSEQ_PH_U          2'h0
`define SWSEQ_PH_V          2'h1
`define SWSEQ_PH_W          2'h2
// zero cross index count per electrical cycle
`define SWSEQ_NUM_CROSS     4'h6
// elapsed cycle counter saturation
`define SWSEQ_CNT_MAX       16'hFFFF

`endif

// ---- dv/swseq_motor_model.sv ----
`timescale 1ns/1ns
module swseq_motor #(
   parameter int SECT = 32'h3E8
) (
   // clock and rotor hold
   input  wire logic       mclk_in,
   input  wire logic       stall_in,
   // comparator levels U,V,W
   output logic      [2:0] zc_out
);
   int cnt = 0;
   int pos = 4;
   // one cross per sector; a stall freezes the rotor
   always @(posedge mclk_in) begin
      if (!stall_in) begin
         cnt <= (cnt == SECT - 1) ? 0 : cnt + 1;
         if (cnt == SECT - 1) pos <= (pos + 1) % 6;
      end
   end
   // order: U rise, W fall, V rise, U fall, W rise, V fall
   assign zc_out = {pos == 0 || pos >= 4, pos >= 2 && pos <= 4, pos < 3};
endmodule // swseq_motor

// ---- dv/swseq_top_assertions.sv ----
`timescale 1ns/1ns
module swseq_chk (
   // clock, reset, controls
   input wire       mclk_in,
   input wire       nrst_in,
   input wire       sine_drive_select_in,
   input wire [1:0] window_count_select_in,
   input wire [4:0] advance_max_clamp_in,
   input wire [2:0] pwm_in,
   input wire [2:0] zc_in,
   // observed outputs
   input wire [2:0] phase_pwm_out,
   input wire [2:0] phase_drive_en_out,
   input wire       zc_event_out,
   input wire       recovery_out,
   input wire [2:0] cross_index_out,
   input wire [4:0] lead_angle_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // idle mode keeps all phases driven and silent
   idle_no_float_a: assert property (!sine_drive_select_in [*2]
      |=> phase_drive_en_out == 3'h7) else $error("float while idle");
   idle_no_event_a: assert property (!sine_drive_select_in [*2]
      |=> !zc_event_out) else $error("event while idle");
   // at most one phase floats, gate follows modulator
   single_float_a: assert property ($past(nrst_in)
      |-> $countones(phase_drive_en_out) >= 2) else $error("two floats");
   pwm_gate_a: assert property (phase_pwm_out ==
      ($past(pwm_in) & phase_drive_en_out)) else $error("gate wrong");
   // a detection needs an open window and a comparator edge
   pulse_edge_a: assert property (zc_event_out
      |-> $past(zc_in) != $past(zc_in, 2)) else $error("no edge");
   pulse_floated_a: assert property (zc_event_out
      |-> $past(phase_drive_en_out) != 3'h7) else $error("not floated");
   six_step_a: assert property (zc_event_out &&
      (recovery_out || $past(window_count_select_in) == 2'h0)
      |-> cross_index_out == ($past(cross_index_out) == 3'h5 ? 3'h0 :
      $past(cross_index_out) + 3'h1)) else $error("index step");
   lead_clamp_a: assert property (
      lead_angle_out <= $past(advance_max_clamp_in)) else $error("clamp");
   // main scenarios
   cover property (zc_event_out);
   cover property ($rose(recovery_out));
   cover property ($fell(recovery_out));
endmodule // swseq_chk
bind swseq_top swseq_chk u_chk (.mclk_in, .nrst_in, .sine_drive_select_in,
   .window_count_select_in, .advance_max_clamp_in, .pwm_in, .zc_in,
   .phase_pwm_out, .phase_drive_en_out, .zc_event_out, .recovery_out,
   .cross_index_out, .lead_angle_out);

// ---- dv/sine_bemf_window_sequencer_tb_top.sv ----
`timescale 1ns/1ns
module sine_bemf_window_sequencer_tb_top;
   logic       mclk_in = 1'b0;
   logic       nrst_in = 1'b0;
   logic       sel     = 1'b0;
   logic       stall   = 1'b0;
   logic [1:0] wcs     = 2'h0;
   logic [5:0] od      = 6'h04;
   logic [5:0] bp      = 6'h04;
   logic [7:0] duty    = 8'h00;
   logic [4:0] az      = 5'h00;
   logic [4:0] af      = 5'h00;
   logic [4:0] amax    = 5'h1F;
   logic [2:0] pwm     = 3'h0;
   logic [2:0] zc, ppwm, den, idx, prev;
   logic [4:0] lead;
   logic       ev, rec;
   int         fail_count = 0, n_tests = 0, seed = 97, cyc = 0, i, k;
   int         steps [4] = '{1, 2, 3, 6};
   // device and motor
   swseq_top #(.PERIOD_INIT(16'h03E8)) dut (.mclk_in(mclk_in),
      .nrst_in(nrst_in), .sine_drive_select_in(sel),
      .window_count_select_in(wcs), .six_win_open_delay_in(od),
      .six_win_blank_period_in(bp), .three_win_open_delay_in(od),
      .three_win_blank_period_in(bp), .two_win_open_delay_in(od),
      .two_win_blank_period_in(bp), .one_win_open_delay_in(od),
      .one_win_blank_period_in(bp), .recovery_open_delay_in(od),
      .recovery_blank_period_in(bp), .advance_at_zero_duty_in(az),
      .advance_at_full_duty_in(af), .advance_max_clamp_in(amax),
      .duty_in(duty), .pwm_in(pwm), .zc_in(zc), .phase_pwm_out(ppwm),
      .phase_drive_en_out(den), .zc_event_out(ev), .recovery_out(rec),
      .cross_index_out(idx), .lead_angle_out(lead));
   swseq_motor u_motor (.mclk_in(mclk_in), .stall_in(stall), .zc_out(zc));
   initial forever #25 mclk_in = ~mclk_in;
   // expected drive enable mask for the sought cross
   function automatic logic [7:0] fmask(input logic [2:0] x);
      if (x == 3'h0 || x == 3'h3) return 8'h06;
      if (x == 3'h2 || x == 3'h5) return 8'h05;
      return 8'h03;
   endfunction
   // expected lead code: interpolate, floor, clamp
   function automatic logic [7:0] flead(input logic [7:0] d,
      input logic [4:0] z, f, m);
      int dd;
      int v;
      dd = int'(d) + int'(d[7]);
      v = (int'(z) * (256 - dd) + int'(f) * dd) / 256;
      return (v > int'(m)) ? 8'(m) : 8'(v);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
      #2;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (e !== g) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // waits for a window, then the detection pulse
   task automatic catch_ev(input int step);
      int t;
      t = 0;
      prev = idx;
      while (den === 3'h7 && t < 9000) begin
         tick(1);
         t++;
      end
      chk("float", fmask(idx), 8'(den));
      while (ev !== 1'b1 && t < 9000) begin
         tick(1);
         t++;
      end
      chk("pulse", 8'h01, 8'(ev));
      if (step != 0) chk("index", 8'((int'(prev) + step) % 6), 8'(idx));
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 90000) begin
         fail_count++;
         end_sim();
      end
   end
   initial begin
      tick(10);
      chk("rst_en", 8'h00, 8'(den));
      nrst_in = 1'b1;
      tick(2);
      chk("idle_en", 8'h07, 8'(den));
      for (i = 0; i < 24; i++) begin
         duty = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
         az = (i < 2) ? 5'h02 : 5'($random(seed));
         af = (i < 2) ? 5'h16 : 5'($random(seed));
         amax = (i < 2) ? 5'h1F : 5'($random(seed));
         pwm = 3'($random(seed));
         tick(2);
         chk("lead", flead(duty, az, af, amax), 8'(lead));
         chk("pwm", 8'(pwm), 8'(ppwm));
      end
      @(zc);
      #2;
      sel = 1'b1;
      catch_ev(1);
      chk("rec_exit", 8'h00, 8'(rec));
      for (k = 0; k < 4; k++) begin
         wcs = k[1:0];
         catch_ev(0);
         for (i = 0; i < 6 && rec === 1'b1; i++) catch_ev(0);
         chk("mode_exit", 8'h00, 8'(rec));
         repeat (2) catch_ev(steps[k]);
      end
      stall = 1'b1;
      prev = idx;
      i = 0;
      while (rec !== 1'b1 && i < 9000) begin
         tick(1);
         i++;
      end
      chk("recovery", 8'h01, 8'(rec));
      chk("rec_index", 8'((int'(prev) + 1) % 6), 8'(idx));
      while (den === 3'h7 && i < 12000) begin
         tick(1);
         i++;
      end
      chk("rec_float", fmask(idx), 8'(den));
      end_sim();
   end
endmodule // sine_bemf_window_sequencer_tb_top
